// >>> iop_pkg.sv
`default_nettype none
package iop_pkg;
  // register byte offsets
  localparam logic [7:0] OFF_DRV0 = 8'h00;
  localparam logic [7:0] OFF_DRV1 = 8'h04;
  localparam logic [7:0] OFF_SUP  = 8'h08;
  localparam logic [7:0] OFF_PORTA_FUNC_SEL_0 = 8'h0C;
  localparam logic [7:0] OFF_PORTA_FUNC_SEL_1 = 8'h10;
  localparam logic [7:0] OFF_PORTB_FUNC_SEL_0 = 8'h14;
  localparam logic [7:0] OFF_PORTB_FUNC_SEL_1 = 8'h18;
  localparam logic [7:0] OFF_PORTC_FUNC_SEL_0 = 8'h1C;
  localparam logic [7:0] OFF_PORTC_FUNC_SEL_1 = 8'h20;
  localparam logic [7:0] OFF_PORTD_FUNC_SEL_0 = 8'h24;
  localparam logic [7:0] OFF_IFS  = 8'h28;
  // implemented bits per register
  localparam logic [7:0] MSK_DRV0 = 8'hFF;
  localparam logic [7:0] MSK_DRV1 = 8'h0F;
  localparam logic [7:0] MSK_SUP  = 8'h0F;
  localparam logic [7:0] MSK_PORTA_FUNC_SEL_0 = 8'hCC;
  localparam logic [7:0] MSK_PORTA_FUNC_SEL_1 = 8'hFF;
  localparam logic [7:0] MSK_PORTB_FUNC_SEL_0 = 8'h03;
  localparam logic [7:0] MSK_PORTB_FUNC_SEL_1 = 8'hFF;
  localparam logic [7:0] MSK_PORTC_FUNC_SEL_0 = 8'hFF;
  localparam logic [7:0] MSK_PORTC_FUNC_SEL_1 = 8'hFF;
  localparam logic [7:0] MSK_PORTD_FUNC_SEL_0 = 8'h0F;
  localparam logic [7:0] MSK_IFS  = 8'h07;
  localparam logic [7:0] RST_REG  = 8'h00;
  // two-bit field positions
  localparam int unsigned POS_76 = 6;
  localparam int unsigned POS_54 = 4;
  localparam int unsigned POS_32 = 2;
  localparam int unsigned POS_10 = 0;
  // single-bit positions
  localparam int unsigned SUP_PD_UPPER = 3;
  localparam int unsigned SUP_PB_UPPER = 1;
  localparam int unsigned IFS_SCL_POS  = 2;
  localparam int unsigned IFS_SDA_POS  = 1;
  localparam int unsigned IFS_RX_POS   = 0;
  // selection and response codes
  localparam logic [1:0] SEL_GPIO = 2'h0;
  localparam logic [1:0] SEL_ALT1 = 2'h1;
  localparam logic [1:0] SEL_ALT2 = 2'h2;
  localparam logic [1:0] SEL_ALT3 = 2'h3;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {DRV_LVL0, DRV_LVL1, DRV_LVL2, DRV_LVL3} iop_drive_t;

  typedef struct packed {
    iop_drive_t pb7_4;
    iop_drive_t pb0;
    iop_drive_t pa7_6;
    iop_drive_t pa3_0;
    iop_drive_t pc7_4;
    iop_drive_t pc3_0;
  } iop_drive_cfg_t;

  typedef struct packed {
    logic [10:0] analog_channel_en;
    logic opamp_inverting_input_0;
    logic opamp_noninverting_input;
    logic serial_module_clock;
    logic opamp_output;
    logic serial_module_data_out;
    logic serial_module_data_in;
    logic periodic_timer0_output;
    logic periodic_timer1_output;
    logic serial_chip_select;
    logic periodic_timer1_output_inv;
    logic usb_detect1_minus;
    logic usb_detect1_plus;
    logic uart_tx;
    logic uart_rx_tx;
    logic standard_timer_output;
    logic reference_voltage_out;
    logic auxiliary_io_supply_in;
    logic standard_timer_output_inv;
    logic usb_detect2_minus;
    logic usb_detect2_plus;
    logic timer2_output;
    logic timer2_output_inv;
    logic i2c_master_data_line;
    logic i2c_master_clock_line;
    logic timer3_output;
    logic timer3_output_inv;
    logic reference_voltage_in;
  } iop_route_t;

  typedef struct packed {
    logic pb45_aux;
    logic pd_lines_aux;
    logic aux_input_selected;
  } iop_supply_t;
endpackage : iop_pkg
`default_nettype wire

// >>> iop_pin_mux.sv
`timescale 1ns/100ps
`default_nettype none
module iop_pin_mux #(
  parameter int unsigned ADDR_W = 8
) (
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  input  wire logic [ADDR_W-1:0]     s_axi_awaddr,
  input  wire logic [2:0]            s_axi_awprot,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [ADDR_W-1:0]     s_axi_araddr,
  input  wire logic [2:0]            s_axi_arprot,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  output iop_pkg::iop_route_t        route_o,
  output iop_pkg::iop_drive_cfg_t    drive_o,
  output iop_pkg::iop_supply_t       supply_o,
  output logic [3:0]                 portd_func_sel_o,
  output logic                       i2c_master_clock_source_sel_o,
  output logic                       i2c_master_data_source_sel_o,
  output logic                       uart_rx_source_sel_o
);
  if (ADDR_W < 8 || ADDR_W > 32) begin : g_chk
    $error("ADDR_W must be 8..32");
  end

  localparam int unsigned NREG = 11;
  localparam logic [7:0] OFFS [NREG] = '{iop_pkg::OFF_DRV0, iop_pkg::OFF_DRV1, iop_pkg::OFF_SUP,
    iop_pkg::OFF_PORTA_FUNC_SEL_0, iop_pkg::OFF_PORTA_FUNC_SEL_1, iop_pkg::OFF_PORTB_FUNC_SEL_0, iop_pkg::OFF_PORTB_FUNC_SEL_1, iop_pkg::OFF_PORTC_FUNC_SEL_0,
    iop_pkg::OFF_PORTC_FUNC_SEL_1, iop_pkg::OFF_PORTD_FUNC_SEL_0, iop_pkg::OFF_IFS};
  localparam logic [7:0] MSKS [NREG] = '{iop_pkg::MSK_DRV0, iop_pkg::MSK_DRV1, iop_pkg::MSK_SUP,
    iop_pkg::MSK_PORTA_FUNC_SEL_0, iop_pkg::MSK_PORTA_FUNC_SEL_1, iop_pkg::MSK_PORTB_FUNC_SEL_0, iop_pkg::MSK_PORTB_FUNC_SEL_1, iop_pkg::MSK_PORTC_FUNC_SEL_0,
    iop_pkg::MSK_PORTC_FUNC_SEL_1, iop_pkg::MSK_PORTD_FUNC_SEL_0, iop_pkg::MSK_IFS};

  function automatic logic [1:0] fld(input logic [7:0] r, input int unsigned pos);
    fld = r[pos +: 2];
  endfunction : fld

  // ---------------- write channel ----------------
  logic              aw_held_ff;
  logic [7:0]        aw_addr_ff;
  logic              w_held_ff;
  logic [7:0]        w_data_ff;
  logic              w_strb0_ff;
  logic              bvalid_ff;
  logic [1:0]        bresp_ff;
  logic [7:0]        regs_ff [NREG];
  logic [NREG-1:0]   wr_hit;
  logic [NREG-1:0]   rd_hit;
  wire               do_write = aw_held_ff && w_held_ff && !bvalid_ff;
  wire               aw_take  = s_axi_awvalid && s_axi_awready;
  wire               w_take   = s_axi_wvalid && s_axi_wready;

  assign s_axi_awready = !aw_held_ff && !bvalid_ff;
  assign s_axi_wready  = !w_held_ff && !bvalid_ff;
  assign s_axi_bvalid  = bvalid_ff;
  assign s_axi_bresp   = bresp_ff;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_ff <= 1'b0;
      aw_addr_ff <= 8'h00;
    end else if (aw_take) begin
      aw_held_ff <= 1'b1;
      aw_addr_ff <= {s_axi_awaddr[7:2], 2'b00};
    end else if (do_write) begin
      aw_held_ff <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_ff  <= 1'b0;
      w_data_ff  <= 8'h00;
      w_strb0_ff <= 1'b0;
    end else if (w_take) begin
      w_held_ff  <= 1'b1;
      w_data_ff  <= s_axi_wdata[7:0];
      w_strb0_ff <= s_axi_wstrb[0];
    end else if (do_write) begin
      w_held_ff <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_ff <= 1'b0;
      bresp_ff  <= iop_pkg::RESP_OKAY;
    end else if (do_write) begin
      bvalid_ff <= 1'b1;
      bresp_ff  <= (|wr_hit) ? iop_pkg::RESP_OKAY : iop_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_ff <= 1'b0;
    end
  end

  // ---------------- register file ----------------
  // unimplemented bits never store, so reserved bits always read zero
  for (genvar i = 0; i < NREG; i++) begin : g_reg
    assign wr_hit[i] = (aw_addr_ff == OFFS[i]);
    assign rd_hit[i] = ({s_axi_araddr[7:2], 2'b00} == OFFS[i]);
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        regs_ff[i] <= iop_pkg::RST_REG;
      end else if (do_write && wr_hit[i] && w_strb0_ff) begin
        regs_ff[i] <= w_data_ff & MSKS[i];
      end
    end
  end

  // ---------------- read channel ----------------
  logic              rvalid_ff;
  logic [31:0]       rdata_ff;
  logic [1:0]        rresp_ff;
  logic [7:0]        rd_mux;
  wire               ar_take = s_axi_arvalid && s_axi_arready;

  always_comb begin
    rd_mux = 8'h00;
    for (int k = 0; k < NREG; k++) begin
      if (rd_hit[k]) begin
        rd_mux = regs_ff[k];
      end
    end
  end

  assign s_axi_arready = !rvalid_ff;
  assign s_axi_rvalid  = rvalid_ff;
  assign s_axi_rdata   = rdata_ff;
  assign s_axi_rresp   = rresp_ff;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_ff <= 1'b0;
      rdata_ff  <= 32'h0000_0000;
      rresp_ff  <= iop_pkg::RESP_OKAY;
    end else if (ar_take) begin
      rvalid_ff <= 1'b1;
      rdata_ff  <= {24'h00_0000, rd_mux};
      rresp_ff  <= (|rd_hit) ? iop_pkg::RESP_OKAY : iop_pkg::RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_ff <= 1'b0;
    end
  end

  // ---------------- field decode ----------------
  wire [7:0] drv0 = regs_ff[0];
  wire [7:0] drv1 = regs_ff[1];
  wire [7:0] sup  = regs_ff[2];
  wire [7:0] porta_func_sel_0 = regs_ff[3];
  wire [7:0] porta_func_sel_1 = regs_ff[4];
  wire [7:0] portb_func_sel_0 = regs_ff[5];
  wire [7:0] portb_func_sel_1 = regs_ff[6];
  wire [7:0] portc_func_sel_0 = regs_ff[7];
  wire [7:0] portc_func_sel_1 = regs_ff[8];
  wire [7:0] portd_func_sel_0 = regs_ff[9];
  wire [7:0] input_source_select  = regs_ff[10];

  wire [1:0] pa3_c = fld(porta_func_sel_0, iop_pkg::POS_76);
  wire [1:0] pa1_c = fld(porta_func_sel_0, iop_pkg::POS_32);
  wire [1:0] pa7_c = fld(porta_func_sel_1, iop_pkg::POS_76);
  wire [1:0] pa6_c = fld(porta_func_sel_1, iop_pkg::POS_54);
  wire [1:0] pb0_c = fld(portb_func_sel_0, iop_pkg::POS_10);
  wire [1:0] pb7_c = fld(portb_func_sel_1, iop_pkg::POS_76);
  wire [1:0] pb6_c = fld(portb_func_sel_1, iop_pkg::POS_54);
  wire [1:0] pb5_c = fld(portb_func_sel_1, iop_pkg::POS_32);
  wire [1:0] pb4_c = fld(portb_func_sel_1, iop_pkg::POS_10);
  wire [1:0] pc3_c = fld(portc_func_sel_0, iop_pkg::POS_76);
  wire [1:0] pc2_c = fld(portc_func_sel_0, iop_pkg::POS_54);
  wire [1:0] pc1_c = fld(portc_func_sel_0, iop_pkg::POS_32);
  wire [1:0] pc0_c = fld(portc_func_sel_0, iop_pkg::POS_10);
  wire [1:0] pc7_c = fld(portc_func_sel_1, iop_pkg::POS_76);
  wire [1:0] pc6_c = fld(portc_func_sel_1, iop_pkg::POS_54);
  wire [1:0] pc5_c = fld(portc_func_sel_1, iop_pkg::POS_32);
  wire [1:0] pc4_c = fld(portc_func_sel_1, iop_pkg::POS_10);

  iop_pkg::iop_route_t     nxt_route;
  iop_pkg::iop_drive_cfg_t nxt_drive;
  iop_pkg::iop_supply_t    nxt_supply;
  iop_pkg::iop_route_t     route_ff;
  iop_pkg::iop_drive_cfg_t drive_ff;
  iop_pkg::iop_supply_t    supply_ff;
  logic [2:0]              ifs_ff;
  logic [3:0]              pds_ff;

  always_comb begin
    nxt_route = '0;
    nxt_route.opamp_inverting_input_0  = (pa3_c == iop_pkg::SEL_ALT1);
    nxt_route.opamp_noninverting_input = (pa3_c == iop_pkg::SEL_ALT2);
    nxt_route.serial_module_clock      = (pa1_c == iop_pkg::SEL_ALT1);
    nxt_route.opamp_output             = (pa1_c == iop_pkg::SEL_ALT2);
    nxt_route.serial_module_data_out   = (pa7_c == iop_pkg::SEL_ALT1);
    nxt_route.periodic_timer0_output   = (pa7_c == iop_pkg::SEL_ALT2);
    nxt_route.serial_module_data_in    = (pa6_c == iop_pkg::SEL_ALT1);
    nxt_route.periodic_timer1_output   = (pa6_c == iop_pkg::SEL_ALT2);
    nxt_route.analog_channel_en[1]     = (pa7_c == iop_pkg::SEL_ALT3);
    nxt_route.analog_channel_en[0]     = (pa6_c == iop_pkg::SEL_ALT3);
    nxt_route.serial_chip_select          = (pb0_c == iop_pkg::SEL_ALT1);
    nxt_route.periodic_timer1_output_inv  = (pb0_c == iop_pkg::SEL_ALT2);
    nxt_route.usb_detect1_minus           = (pb7_c == iop_pkg::SEL_ALT1);
    nxt_route.usb_detect1_plus            = (pb6_c == iop_pkg::SEL_ALT1);
    nxt_route.analog_channel_en[3]        = (pb7_c == iop_pkg::SEL_ALT2);
    nxt_route.analog_channel_en[2]        = (pb6_c == iop_pkg::SEL_ALT2);
    nxt_route.uart_tx                     = (pb5_c == iop_pkg::SEL_ALT1);
    nxt_route.uart_rx_tx                  = (pb4_c == iop_pkg::SEL_ALT1);
    nxt_route.standard_timer_output       = (pc3_c == iop_pkg::SEL_ALT1);
    nxt_route.analog_channel_en[6]        = (pc3_c == iop_pkg::SEL_ALT2);
    nxt_route.reference_voltage_out       = (pc3_c == iop_pkg::SEL_ALT3);
    nxt_route.auxiliary_io_supply_in      = (pc2_c == iop_pkg::SEL_ALT1);
    nxt_route.standard_timer_output_inv   = (pc2_c == iop_pkg::SEL_ALT2);
    nxt_route.usb_detect2_minus           = (pc1_c == iop_pkg::SEL_ALT1);
    nxt_route.usb_detect2_plus            = (pc0_c == iop_pkg::SEL_ALT1);
    nxt_route.analog_channel_en[5]        = (pc1_c == iop_pkg::SEL_ALT2);
    nxt_route.analog_channel_en[4]        = (pc0_c == iop_pkg::SEL_ALT2);
    nxt_route.timer2_output               = (pc7_c == iop_pkg::SEL_ALT1);
    nxt_route.timer2_output_inv           = (pc6_c == iop_pkg::SEL_ALT1);
    nxt_route.i2c_master_data_line        = (pc7_c == iop_pkg::SEL_ALT2);
    nxt_route.i2c_master_clock_line       = (pc6_c == iop_pkg::SEL_ALT2);
    nxt_route.analog_channel_en[10]       = (pc7_c == iop_pkg::SEL_ALT3);
    nxt_route.analog_channel_en[9]        = (pc6_c == iop_pkg::SEL_ALT3);
    nxt_route.timer3_output               = (pc5_c == iop_pkg::SEL_ALT1);
    nxt_route.analog_channel_en[8]        = (pc5_c == iop_pkg::SEL_ALT2);
    nxt_route.timer3_output_inv           = (pc4_c == iop_pkg::SEL_ALT1);
    nxt_route.analog_channel_en[7]        = (pc4_c == iop_pkg::SEL_ALT2);
    nxt_route.reference_voltage_in        = (pc4_c == iop_pkg::SEL_ALT3);
  end

  // enum order gives code 00 = level 0 up to 11 = level 3
  always_comb begin
    nxt_drive.pb7_4 = iop_pkg::iop_drive_t'(fld(drv0, iop_pkg::POS_76));
    nxt_drive.pb0   = iop_pkg::iop_drive_t'(fld(drv0, iop_pkg::POS_54));
    nxt_drive.pa7_6 = iop_pkg::iop_drive_t'(fld(drv0, iop_pkg::POS_32));
    nxt_drive.pa3_0 = iop_pkg::iop_drive_t'(fld(drv0, iop_pkg::POS_10));
    nxt_drive.pc7_4 = iop_pkg::iop_drive_t'(fld(drv1, iop_pkg::POS_32));
    nxt_drive.pc3_0 = iop_pkg::iop_drive_t'(fld(drv1, iop_pkg::POS_10));
  end

  // pb4/pb5 only carry digital functions (gpio or uart), never analog;
  // the internal pd lines are always digital, so the gate is trivially met there
  wire pb45_digital = 1'b1;
  always_comb begin
    nxt_supply.pd_lines_aux       = sup[iop_pkg::SUP_PD_UPPER];
    nxt_supply.pb45_aux           = sup[iop_pkg::SUP_PB_UPPER] && pb45_digital;
    nxt_supply.aux_input_selected = nxt_route.auxiliary_io_supply_in;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      route_ff  <= '0;
      drive_ff  <= '0;
      supply_ff <= '0;
      ifs_ff    <= 3'h0;
      pds_ff    <= 4'h0;
    end else begin
      route_ff  <= nxt_route;
      drive_ff  <= nxt_drive;
      supply_ff <= nxt_supply;
      ifs_ff    <= input_source_select[2:0];
      pds_ff    <= portd_func_sel_0[3:0];
    end
  end

  assign route_o                       = route_ff;
  assign drive_o                       = drive_ff;
  assign supply_o                      = supply_ff;
  assign portd_func_sel_o              = pds_ff;
  assign i2c_master_clock_source_sel_o = ifs_ff[iop_pkg::IFS_SCL_POS];
  assign i2c_master_data_source_sel_o  = ifs_ff[iop_pkg::IFS_SDA_POS];
  assign uart_rx_source_sel_o          = ifs_ff[iop_pkg::IFS_RX_POS];

  // ---------------- assertions ----------------
  wire wr_drv0 = do_write && w_strb0_ff && (aw_addr_ff == iop_pkg::OFF_DRV0);
  property p_drv0_map;
    @(posedge aclk) disable iff (!aresetn)
      wr_drv0 |=> ##1 (drive_o.pb7_4 == $past(w_data_ff[7:6], 2)) && (drive_o.pa3_0 == $past(w_data_ff[1:0], 2));
  endproperty
  a_drv0_map: assert property (p_drv0_map) else $error("drive reg 0 field map wrong");

  property p_drv1_upper;
    @(posedge aclk) disable iff (!aresetn)
      (ar_take && rd_hit[1]) |=> (s_axi_rdata[31:4] == 28'h000_0000);
  endproperty
  a_drv1_upper: assert property (p_drv1_upper) else $error("drive reg 1 upper bits nonzero");

  property p_pd_supply;
    @(posedge aclk) disable iff (!aresetn)
      ##1 supply_o.pd_lines_aux == $past(regs_ff[2][3]);
  endproperty
  a_pd_supply: assert property (p_pd_supply) else $error("pd line supply select wrong");

  property p_pb_supply;
    @(posedge aclk) disable iff (!aresetn)
      (regs_ff[2][1] && $stable(regs_ff[2])) |=> supply_o.pb45_aux;
  endproperty
  a_pb_supply: assert property (p_pb_supply) else $error("pb4/5 supply not aux");

  property p_pa3_route;
    @(posedge aclk) disable iff (!aresetn)
      route_o.opamp_inverting_input_0 |-> $past(porta_func_sel_0[7:6]) == iop_pkg::SEL_ALT1 && !route_o.opamp_noninverting_input;
  endproperty
  a_pa3_route: assert property (p_pa3_route) else $error("pa3 routing wrong");

  property p_porta_func_sel_0_read;
    @(posedge aclk) disable iff (!aresetn)
      (ar_take && rd_hit[3]) |=> (s_axi_rdata[5:4] == 2'b00) && (s_axi_rdata[1:0] == 2'b00);
  endproperty
  a_porta_func_sel_0_read: assert property (p_porta_func_sel_0_read) else $error("port a reg 0 reserved bits nonzero");

  property p_pa7_analog;
    @(posedge aclk) disable iff (!aresetn)
      (pa7_c == iop_pkg::SEL_ALT3) ##1 (pa7_c == iop_pkg::SEL_ALT3) |-> route_o.analog_channel_en[1];
  endproperty
  a_pa7_analog: assert property (p_pa7_analog) else $error("pa7 analog not routed");

  property p_uart;
    @(posedge aclk) disable iff (!aresetn)
      route_o.uart_tx |-> $past(portb_func_sel_1[3:2]) == iop_pkg::SEL_ALT1;
  endproperty
  a_uart: assert property (p_uart) else $error("uart tx routed on wrong code");

  property p_pc3_ref;
    @(posedge aclk) disable iff (!aresetn)
      route_o.reference_voltage_out |-> $past(portc_func_sel_0[7:6]) == iop_pkg::SEL_ALT3 && !route_o.analog_channel_en[6];
  endproperty
  a_pc3_ref: assert property (p_pc3_ref) else $error("pc3 reference routing wrong");

  property p_i2c_src;
    @(posedge aclk) disable iff (!aresetn)
      ##1 i2c_master_clock_source_sel_o == $past(regs_ff[10][2]);
  endproperty
  a_i2c_src: assert property (p_i2c_src) else $error("i2c clock source select wrong");

  property p_reset_zero;
    @(posedge aclk) !aresetn |=> (route_o == '0) && (drive_o == '0) && (supply_o == '0);
  endproperty
  a_reset_zero: assert property (p_reset_zero) else $error("outputs not cleared by reset");
endmodule : iop_pin_mux
`default_nettype wire

// >>> tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic                    aclk;
  logic                    aresetn;
  logic [7:0]              s_axi_awaddr, s_axi_araddr;
  logic [2:0]              s_axi_awprot, s_axi_arprot;
  logic [31:0]             s_axi_wdata, s_axi_rdata;
  logic [3:0]              s_axi_wstrb;
  logic                    s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic                    s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]              s_axi_bresp, s_axi_rresp;
  iop_pkg::iop_route_t     route_o;
  iop_pkg::iop_route_t     er;
  iop_pkg::iop_drive_cfg_t drive_o;
  iop_pkg::iop_supply_t    supply_o;
  logic [3:0]              portd_func_sel_o;
  logic                    i2c_master_clock_source_sel_o, i2c_master_data_source_sel_o, uart_rx_source_sel_o;
  logic [31:0]             rdat;
  logic [1:0]              rsp;
  int                      error_cnt, check_count;
  logic [7:0] offs [11] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C, 8'h20, 8'h24, 8'h28};
  logic [7:0] msks [11] = '{8'hFF, 8'h0F, 8'h0F, 8'hCC, 8'hFF, 8'h03, 8'hFF, 8'hFF, 8'hFF, 8'h0F, 8'h07};
  // patterns software may legally write: no aux supply, port a reserved bits kept, port d codes 01 only
  logic [7:0] pats [11] = '{8'hFF, 8'hFF, 8'h55, 8'hFF, 8'hF0, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h55, 8'hFE};

  iop_pin_mux u_iop_pin_mux (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .route_o, .drive_o, .supply_o, .portd_func_sel_o, .i2c_master_clock_source_sel_o,
    .i2c_master_data_source_sel_o, .uart_rx_source_sel_o);

  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  task automatic tally_and_finish;
    if (error_cnt == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : tally_and_finish

  task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string msg);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t %s got %0h exp %0h", $time, msg, got, exp);
    end
  endtask : chk

  // one idle edge at the end so back-to-back calls never drive a signal twice in a step
  // no cycle limit here: only the watchdog ends a hung wait
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] r);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_wstrb   <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask : rd

  task automatic wrc(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    wr(a, d, 4'hF, r);
    chk(r, iop_pkg::RESP_OKAY, "bresp");
  endtask : wrc

  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0]  r;
    rd(a, d, r);
    chk(d, e, "rdata");
    chk(r, iop_pkg::RESP_OKAY, "rresp");
  endtask : rdc

  // outputs follow the register one edge later
  task automatic settle;
    repeat (2) @(posedge aclk);
  endtask : settle

  task automatic rt(input logic [7:0] a, input logic [31:0] d);
    wrc(a, d);
    settle();
    chk(route_o, er, "route");
    wrc(a, 32'h0);
    er = '0;
  endtask : rt

  initial begin
    repeat (20000) @(posedge aclk);
    error_cnt++;
    tally_and_finish();
  end

  initial begin
    error_cnt = 0;
    check_count = 0;
    er = '0;
    aresetn = 1'b0;
    {s_axi_awaddr, s_axi_araddr, s_axi_awprot, s_axi_arprot, s_axi_wdata, s_axi_wstrb} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk({route_o, drive_o, supply_o}, 64'h0, "reset outputs");
    for (int i = 0; i < 11; i++) begin
      rdc(offs[i], 32'h0);
      wrc(offs[i], {24'hFF_FFFF, pats[i]});
      rdc(offs[i], {24'h0, pats[i] & msks[i]});
      wrc(offs[i], 32'h0);
    end
    wr(8'h2C, 32'hFF, 4'hF, rsp);
    chk(rsp, iop_pkg::RESP_SLVERR, "unmapped write");
    rd(8'h2C, rdat, rsp);
    chk({rdat, rsp}, {32'h0, iop_pkg::RESP_SLVERR}, "unmapped read");
    // byte lane 0 disabled: response is fine but nothing lands
    wr(iop_pkg::OFF_PORTC_FUNC_SEL_1, 32'hFF, 4'h0, rsp);
    chk(rsp, iop_pkg::RESP_OKAY, "no-strobe write");
    rdc(iop_pkg::OFF_PORTC_FUNC_SEL_1, 32'h0);
    wrc(iop_pkg::OFF_DRV0, 32'hE4);
    wrc(iop_pkg::OFF_DRV1, 32'hFB);
    settle();
    chk(drive_o, {iop_pkg::DRV_LVL3, iop_pkg::DRV_LVL2, iop_pkg::DRV_LVL1, iop_pkg::DRV_LVL0,
                  iop_pkg::DRV_LVL2, iop_pkg::DRV_LVL3}, "drive");
    wrc(iop_pkg::OFF_PORTC_FUNC_SEL_0, 32'h10);
    wrc(iop_pkg::OFF_SUP, 32'h08);
    settle();
    chk(supply_o, 3'b011, "supply pd");
    wrc(iop_pkg::OFF_SUP, 32'h06);
    settle();
    chk(supply_o, 3'b101, "supply pb");
    wrc(iop_pkg::OFF_SUP, 32'h00);
    wrc(iop_pkg::OFF_PORTC_FUNC_SEL_0, 32'h00);
    wrc(iop_pkg::OFF_PORTD_FUNC_SEL_0, 32'h05);
    settle();
    chk({portd_func_sel_o, i2c_master_clock_source_sel_o, i2c_master_data_source_sel_o, uart_rx_source_sel_o},
        7'h28, "port d internal i2c");
    wrc(iop_pkg::OFF_PORTD_FUNC_SEL_0, 32'h00);
    wrc(iop_pkg::OFF_IFS, 32'h06);
    settle();
    chk({portd_func_sel_o, i2c_master_clock_source_sel_o, i2c_master_data_source_sel_o, uart_rx_source_sel_o},
        7'h06, "pin i2c sources");
    er.opamp_inverting_input_0 = 1'b1;
    er.serial_module_clock = 1'b1;
    rt(iop_pkg::OFF_PORTA_FUNC_SEL_0, 32'h44);
    er.opamp_noninverting_input = 1'b1;
    er.opamp_output = 1'b1;
    rt(iop_pkg::OFF_PORTA_FUNC_SEL_0, 32'h88);
    rt(iop_pkg::OFF_PORTA_FUNC_SEL_0, 32'hCC);
    er.serial_module_data_out = 1'b1;
    er.serial_module_data_in = 1'b1;
    rt(iop_pkg::OFF_PORTA_FUNC_SEL_1, 32'h50);
    er.periodic_timer0_output = 1'b1;
    er.periodic_timer1_output = 1'b1;
    rt(iop_pkg::OFF_PORTA_FUNC_SEL_1, 32'hA0);
    er.analog_channel_en = 11'h003;
    rt(iop_pkg::OFF_PORTA_FUNC_SEL_1, 32'hF0);
    er.serial_chip_select = 1'b1;
    rt(iop_pkg::OFF_PORTB_FUNC_SEL_0, 32'h01);
    er.analog_channel_en = 11'h00C;
    rt(iop_pkg::OFF_PORTB_FUNC_SEL_1, 32'hA0);
    er.analog_channel_en = 11'h040;
    rt(iop_pkg::OFF_PORTC_FUNC_SEL_0, 32'h80);
    er.timer2_output = 1'b1;
    er.timer2_output_inv = 1'b1;
    er.timer3_output = 1'b1;
    er.timer3_output_inv = 1'b1;
    rt(iop_pkg::OFF_PORTC_FUNC_SEL_1, 32'h55);
    er.periodic_timer1_output_inv = 1'b1;
    rt(iop_pkg::OFF_PORTB_FUNC_SEL_0, 32'h02);
    er.usb_detect1_minus = 1'b1;
    er.usb_detect1_plus = 1'b1;
    er.uart_tx = 1'b1;
    er.uart_rx_tx = 1'b1;
    rt(iop_pkg::OFF_PORTB_FUNC_SEL_1, 32'h55);
    er.reference_voltage_out = 1'b1;
    er.auxiliary_io_supply_in = 1'b1;
    er.usb_detect2_minus = 1'b1;
    er.usb_detect2_plus = 1'b1;
    rt(iop_pkg::OFF_PORTC_FUNC_SEL_0, 32'hD5);
    er.standard_timer_output = 1'b1;
    er.standard_timer_output_inv = 1'b1;
    er.analog_channel_en = 11'h030;
    rt(iop_pkg::OFF_PORTC_FUNC_SEL_0, 32'h6A);
    er.i2c_master_data_line = 1'b1;
    er.i2c_master_clock_line = 1'b1;
    er.analog_channel_en = 11'h100;
    er.reference_voltage_in = 1'b1;
    rt(iop_pkg::OFF_PORTC_FUNC_SEL_1, 32'hAB);
    er.analog_channel_en = 11'h680;
    rt(iop_pkg::OFF_PORTC_FUNC_SEL_1, 32'hF2);
    tally_and_finish();
  end
endmodule : tb_top
`default_nettype wire
